// file: hdl/gps_pkg.sv
package gps_pkg;
    // ------------------------------------------------------------
    // port geometry
    // ------------------------------------------------------------
    localparam int NUM_PINS = 6;
    localparam int OUT_ONLY_IDX = 4;
    localparam int IN_ONLY_IDX = 5;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_DIR = 8'h04;
    localparam logic [7:0] OFS_PULL = 8'h08;
    localparam logic [7:0] OFS_SLEW = 8'h0C;
    localparam logic [7:0] OFS_DRIVE = 8'h10;
    localparam logic [7:0] OFS_PMSC = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_EN = 8'h1C;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h20;
    localparam logic [7:0] OFS_ALT_EN = 8'h24;
    localparam logic [7:0] OFS_ANA_EN = 8'h28;
    localparam logic [7:0] OFS_PIN_CFG = 8'h2C;

    // ------------------------------------------------------------
    // power_mode_status_control fields and reset values
    // ------------------------------------------------------------
    localparam int PM_SELECT_BIT = 0;
    localparam int PM_ACK_BIT = 2;
    localparam int PM_FLAG_BIT = 3;
    localparam logic [7:0] PM_RESET = 8'h00;

    // pin configuration register: bit 0 hands the output-only pin to GPIO
    localparam int CFG_OUT_ONLY_GPIO_BIT = 0;

    // interrupt status layout
    localparam int IRQ_W = 2;
    localparam int IRQ_WAKE_BIT = 0;
    localparam int IRQ_STOP_BIT = 1;

    localparam logic [5:0] PIN_RESET = 6'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    // ------------------------------------------------------------
    // sleep states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SLP_RUN = 2'b00,
        SLP_POWERED_LOGIC = 2'b01,
        SLP_RETAINED_PIN = 2'b10,
        SLP_FULL_OFF = 2'b11
    } gps_sleep_t;
endpackage : gps_pkg

// file: hdl/gps_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
module gps_pin_cell #(
    parameter bit OUT_ONLY = 1'b0,
    parameter bit IN_ONLY = 1'b0
) (
    input wire logic dirBit,
    input wire logic dataBit,
    input wire logic pullBit,
    input wire logic digEn,
    input wire logic anaEn,
    input wire logic altOe,
    input wire logic altOut,
    input wire logic pinLevel,
    output logic drvOut,
    output logic drvOe,
    output logic pullOn,
    output logic inBufOn,
    output logic readBit
);
    logic digOwns;
    logic effDir;

    always_comb begin
        // analog wins over a digital function on the same pin
        digOwns = digEn && !anaEn;
        effDir = IN_ONLY ? 1'b0 : (OUT_ONLY ? 1'b1 : dirBit);
        inBufOn = !anaEn && !OUT_ONLY;
        if (anaEn) begin
            drvOe = 1'b0;
            drvOut = 1'b0;
        end else if (digOwns) begin
            drvOe = altOe && !IN_ONLY;
            drvOut = altOut;
        end else begin
            drvOe = effDir && !IN_ONLY;
            drvOut = dataBit;
        end
        // pullup only on a pin that nothing drives and no analog owns
        pullOn = pullBit && !drvOe && !anaEn && !OUT_ONLY;
        // direction still picks the read source under a digital function
        if (effDir) begin
            readBit = dataBit;
        end else if (inBufOn) begin
            readBit = pinLevel;
        end else begin
            readBit = 1'b0;
        end
    end
endmodule : gps_pin_cell
`default_nettype wire

// file: hdl/gps_sleep_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module gps_sleep_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic stopReq,
    input wire logic wakeReq,
    input wire logic fullOffReq,
    input wire logic pmWrite,
    input wire logic [7:0] pmWdata,
    output logic [7:0] pmRead,
    output gps_pkg::gps_sleep_t sleepState,
    output logic holdPins,
    output logic padsOff,
    output logic ioWipe,
    output logic wakeEvt,
    output logic stopEvt
);
    import gps_pkg::*;

    gps_sleep_t state_ff, nxt_state;
    logic select_ff, nxt_select;
    logic selectLocked_ff, nxt_selectLocked;
    logic flag_ff, nxt_flag;
    logic hold_ff, nxt_hold;
    logic ack;

    // ------------------------------------------------------------
    // sleep sequencing and status bits
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_select = select_ff;
        nxt_selectLocked = selectLocked_ff;
        nxt_hold = hold_ff;
        ioWipe = 1'b0;
        wakeEvt = 1'b0;
        stopEvt = 1'b0;
        ack = pmWrite && pmWdata[PM_ACK_BIT];
        // only the first write after reset lands in the select bit
        if (pmWrite && !selectLocked_ff) begin
            nxt_select = pmWdata[PM_SELECT_BIT];
            nxt_selectLocked = 1'b1;
        end
        unique case (state_ff)
            SLP_RUN: begin
                if (stopReq) begin
                    stopEvt = 1'b1;
                    if (fullOffReq) begin
                        nxt_state = SLP_FULL_OFF;
                    end else if (select_ff) begin
                        nxt_state = SLP_RETAINED_PIN;
                    end else begin
                        nxt_state = SLP_POWERED_LOGIC;
                    end
                end
            end
            SLP_POWERED_LOGIC: begin
                // everything stays powered, nothing is touched
                if (wakeReq) begin
                    nxt_state = SLP_RUN;
                    wakeEvt = 1'b1;
                end
            end
            SLP_RETAINED_PIN: begin
                nxt_hold = 1'b1;
                if (wakeReq) begin
                    nxt_state = SLP_RUN;
                    wakeEvt = 1'b1;
                    ioWipe = 1'b1;
                end
            end
            SLP_FULL_OFF: begin
                if (wakeReq) begin
                    nxt_state = SLP_RUN;
                    wakeEvt = 1'b1;
                    ioWipe = 1'b1;
                end
            end
        endcase
        // the pins stay latched until software acknowledges recovery
        if (ack && state_ff == SLP_RUN) begin
            nxt_hold = 1'b0;
        end
        // recovery sets the flag; a set in the acknowledge cycle wins
        nxt_flag = (flag_ff && !ack) || (state_ff == SLP_RETAINED_PIN && wakeReq);
        pmRead = PM_RESET;
        pmRead[PM_SELECT_BIT] = select_ff;
        pmRead[PM_FLAG_BIT] = flag_ff;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= SLP_RUN;
            select_ff <= 1'b0;
            selectLocked_ff <= 1'b0;
            flag_ff <= 1'b0;
            hold_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            select_ff <= nxt_select;
            selectLocked_ff <= nxt_selectLocked;
            flag_ff <= nxt_flag;
            hold_ff <= nxt_hold;
        end
    end

    assign sleepState = state_ff;
    assign holdPins = hold_ff || state_ff == SLP_RETAINED_PIN;
    assign padsOff = state_ff == SLP_FULL_OFF;
endmodule : gps_sleep_ctrl
`default_nettype wire

// file: hdl/gps_port.sv
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - an enabled shared peripheral takes the pin from general-purpose I/O
// - reset: peripherals off, all pins inputs, pullups off, output-only pin in debug role
// - direction bit enables the output buffer and picks latch or pin for reads
// - input buffer always on except analog pins and the output-only pin
// - shared digital function drives output enable; direction still picks read source
// - analog function turns off both input and output buffers
// - input-direction bit with its input buffer off reads zero
// - analog function wins when digital and analog are both enabled
// - pullup, slew and drive registers act independently of data and direction; the pullup is switched off while the pin drives
// - full-off sleep resets all I/O state; software reconfigures afterwards
// - retained-pin sleep holds every pin at its pre-stop state
// - powered-logic sleep keeps all state and resumes unchanged
// - status bit 3 reads one after recovery from retained-pin sleep
// - writing one to bit 2 clears the recovery flag
// - bit 0 picks retained-pin or powered-logic sleep; write-once after reset
module gps_port (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gps_pkg::ADDR_W-1:0] paddr,
    input wire logic [gps_pkg::DATA_W-1:0] pwdata,
    output logic pready,
    output logic [gps_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    input wire logic [gps_pkg::NUM_PINS-1:0] pinIn,
    output logic [gps_pkg::NUM_PINS-1:0] pinOut,
    output logic [gps_pkg::NUM_PINS-1:0] pinOe,
    output logic [gps_pkg::NUM_PINS-1:0] pinPullup,
    output logic [gps_pkg::NUM_PINS-1:0] pinSlew,
    output logic [gps_pkg::NUM_PINS-1:0] pinDrive,
    output logic [gps_pkg::NUM_PINS-1:0] pinInBufEn,
    input wire logic [gps_pkg::NUM_PINS-1:0] periphDigReq,
    input wire logic [gps_pkg::NUM_PINS-1:0] periphAnaReq,
    input wire logic [gps_pkg::NUM_PINS-1:0] periphOe,
    input wire logic [gps_pkg::NUM_PINS-1:0] periphOut,
    input wire logic dbgOe,
    input wire logic dbgOut,
    input wire logic stopReq,
    input wire logic wakeReq,
    input wire logic fullOffReq,
    output gps_pkg::gps_sleep_t sleepState,
    output logic irq
);
    import gps_pkg::*;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [NUM_PINS-1:0] data_ff, nxt_data;
    logic [NUM_PINS-1:0] dir_ff, nxt_dir;
    logic [NUM_PINS-1:0] pull_ff, nxt_pull;
    logic [NUM_PINS-1:0] slew_ff, nxt_slew;
    logic [NUM_PINS-1:0] drive_ff, nxt_drive;
    logic [NUM_PINS-1:0] altEn_ff, nxt_altEn;
    logic [NUM_PINS-1:0] anaEn_ff, nxt_anaEn;
    logic outOnlyGpio_ff, nxt_outOnlyGpio;
    logic [IRQ_W-1:0] irqStat_ff, nxt_irqStat;
    logic [IRQ_W-1:0] irqEn_ff, nxt_irqEn;
    logic [DATA_W-1:0] prdata_ff, nxt_prdata;
    logic pslverr_ff, nxt_pslverr;

    logic [NUM_PINS-1:0] padOut_ff, nxt_padOut;
    logic [NUM_PINS-1:0] padOe_ff, nxt_padOe;
    logic [NUM_PINS-1:0] padPull_ff, nxt_padPull;
    logic [NUM_PINS-1:0] padSlew_ff, nxt_padSlew;
    logic [NUM_PINS-1:0] padDrive_ff, nxt_padDrive;
    logic [NUM_PINS-1:0] padInBuf_ff, nxt_padInBuf;

    logic setup;
    logic wrAcc;
    logic rdAcc;
    logic mapped;
    logic [7:0] pmRead;
    logic holdPins;
    logic padsOff;
    logic ioWipe;
    logic wakeEvt;
    logic stopEvt;

    logic [NUM_PINS-1:0] digEnVec;
    logic [NUM_PINS-1:0] anaEnVec;
    logic [NUM_PINS-1:0] altOeVec;
    logic [NUM_PINS-1:0] altOutVec;
    logic [NUM_PINS-1:0] cellOut;
    logic [NUM_PINS-1:0] cellOe;
    logic [NUM_PINS-1:0] cellPull;
    logic [NUM_PINS-1:0] cellInBuf;
    logic [NUM_PINS-1:0] cellRead;
    logic [NUM_PINS-1:0] dirRead;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign setup = psel && !penable;
    assign wrAcc = psel && penable && pwrite;
    assign rdAcc = setup && !pwrite;

    always_comb begin
        unique case (paddr)
            OFS_DATA, OFS_DIR, OFS_PULL, OFS_SLEW, OFS_DRIVE, OFS_PMSC,
            OFS_IRQ_STAT, OFS_IRQ_EN, OFS_IRQ_CLR, OFS_ALT_EN, OFS_ANA_EN,
            OFS_PIN_CFG: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // power mode status/control and sleep sequencing
    // ------------------------------------------------------------
    gps_sleep_ctrl u_sleep (
        .clk(clk),
        .rst_b(rst_b),
        .stopReq(stopReq),
        .wakeReq(wakeReq),
        .fullOffReq(fullOffReq),
        .pmWrite(wrAcc && paddr == OFS_PMSC),
        .pmWdata(pwdata[7:0]),
        .pmRead(pmRead),
        .sleepState(sleepState),
        .holdPins(holdPins),
        .padsOff(padsOff),
        .ioWipe(ioWipe),
        .wakeEvt(wakeEvt),
        .stopEvt(stopEvt)
    );

    // ------------------------------------------------------------
    // per-pin ownership and buffer gating
    // ------------------------------------------------------------
    always_comb begin
        // a requesting peripheral owns a pin once software has enabled it; debug owns the output-only pin until bit 0 of the pin configuration register is set
        digEnVec = periphDigReq & altEn_ff;
        anaEnVec = periphAnaReq & anaEn_ff;
        altOeVec = periphOe;
        altOutVec = periphOut;
        if (!outOnlyGpio_ff) begin
            digEnVec[OUT_ONLY_IDX] = 1'b1;
            altOeVec[OUT_ONLY_IDX] = dbgOe;
            altOutVec[OUT_ONLY_IDX] = dbgOut;
        end
        // the input-only pin has no direction bit to read back
        dirRead = dir_ff;
        dirRead[IN_ONLY_IDX] = 1'b0;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            gps_pin_cell #(
                .OUT_ONLY(gi == OUT_ONLY_IDX),
                .IN_ONLY(gi == IN_ONLY_IDX)
            ) u_cell (
                .dirBit(dir_ff[gi]),
                .dataBit(data_ff[gi]),
                .pullBit(pull_ff[gi]),
                .digEn(digEnVec[gi]),
                .anaEn(anaEnVec[gi]),
                .altOe(altOeVec[gi]),
                .altOut(altOutVec[gi]),
                .pinLevel(pinIn[gi]),
                .drvOut(cellOut[gi]),
                .drvOe(cellOe[gi]),
                .pullOn(cellPull[gi]),
                .inBufOn(cellInBuf[gi]),
                .readBit(cellRead[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_comb begin
        nxt_data = data_ff;
        nxt_dir = dir_ff;
        nxt_pull = pull_ff;
        nxt_slew = slew_ff;
        nxt_drive = drive_ff;
        nxt_altEn = altEn_ff;
        nxt_anaEn = anaEn_ff;
        nxt_outOnlyGpio = outOnlyGpio_ff;
        nxt_irqEn = irqEn_ff;
        if (wrAcc) begin
            unique case (paddr)
                OFS_DATA: nxt_data = pwdata[NUM_PINS-1:0];
                OFS_DIR: nxt_dir = pwdata[NUM_PINS-1:0];
                OFS_PULL: nxt_pull = pwdata[NUM_PINS-1:0];
                OFS_SLEW: nxt_slew = pwdata[NUM_PINS-1:0];
                OFS_DRIVE: nxt_drive = pwdata[NUM_PINS-1:0];
                OFS_ALT_EN: nxt_altEn = pwdata[NUM_PINS-1:0];
                OFS_ANA_EN: nxt_anaEn = pwdata[NUM_PINS-1:0];
                OFS_PIN_CFG: nxt_outOnlyGpio = pwdata[CFG_OUT_ONLY_GPIO_BIT];
                OFS_IRQ_EN: nxt_irqEn = pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
        // waking from a powered-down sleep leaves I/O registers at reset
        if (ioWipe) begin
            nxt_data = PIN_RESET;
            nxt_dir = PIN_RESET;
            nxt_pull = PIN_RESET;
            nxt_slew = PIN_RESET;
            nxt_drive = PIN_RESET;
            nxt_altEn = PIN_RESET;
            nxt_anaEn = PIN_RESET;
            nxt_outOnlyGpio = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // interrupts: sticky status, a new event beats a clear
    // ------------------------------------------------------------
    always_comb begin
        nxt_irqStat = irqStat_ff;
        if (wrAcc && paddr == OFS_IRQ_CLR) begin
            nxt_irqStat = irqStat_ff & ~pwdata[IRQ_W-1:0];
        end
        if (wakeEvt) begin
            nxt_irqStat[IRQ_WAKE_BIT] = 1'b1;
        end
        if (stopEvt) begin
            nxt_irqStat[IRQ_STOP_BIT] = 1'b1;
        end
    end

    assign irq = |(irqStat_ff & irqEn_ff);

    // ------------------------------------------------------------
    // read data, captured in the setup cycle
    // ------------------------------------------------------------
    always_comb begin
        nxt_prdata = prdata_ff;
        nxt_pslverr = 1'b0;
        if (setup) begin
            nxt_prdata = '0;
            nxt_pslverr = !mapped;
        end
        if (rdAcc) begin
            unique case (paddr)
                OFS_DATA: nxt_prdata[NUM_PINS-1:0] = cellRead;
                OFS_DIR: nxt_prdata[NUM_PINS-1:0] = dirRead;
                OFS_PULL: nxt_prdata[NUM_PINS-1:0] = pull_ff;
                OFS_SLEW: nxt_prdata[NUM_PINS-1:0] = slew_ff;
                OFS_DRIVE: nxt_prdata[NUM_PINS-1:0] = drive_ff;
                OFS_PMSC: nxt_prdata[7:0] = pmRead;
                OFS_IRQ_STAT: nxt_prdata[IRQ_W-1:0] = irqStat_ff;
                OFS_IRQ_EN: nxt_prdata[IRQ_W-1:0] = irqEn_ff;
                OFS_ALT_EN: nxt_prdata[NUM_PINS-1:0] = altEn_ff;
                OFS_ANA_EN: nxt_prdata[NUM_PINS-1:0] = anaEn_ff;
                OFS_PIN_CFG: nxt_prdata[CFG_OUT_ONLY_GPIO_BIT] = outOnlyGpio_ff;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pad drive: these flops are the retention latches
    // ------------------------------------------------------------
    always_comb begin
        if (padsOff) begin
            nxt_padOut = PIN_RESET;
            nxt_padOe = PIN_RESET;
            nxt_padPull = PIN_RESET;
            nxt_padSlew = PIN_RESET;
            nxt_padDrive = PIN_RESET;
            nxt_padInBuf = PIN_RESET;
        end else if (holdPins) begin
            // register wipe on wake must not reach the pins before the ack
            nxt_padOut = padOut_ff;
            nxt_padOe = padOe_ff;
            nxt_padPull = padPull_ff;
            nxt_padSlew = padSlew_ff;
            nxt_padDrive = padDrive_ff;
            nxt_padInBuf = padInBuf_ff;
        end else begin
            nxt_padOut = cellOut;
            nxt_padOe = cellOe;
            nxt_padPull = cellPull;
            nxt_padSlew = slew_ff;
            nxt_padDrive = drive_ff;
            nxt_padInBuf = cellInBuf;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            data_ff <= PIN_RESET;
            dir_ff <= PIN_RESET;
            pull_ff <= PIN_RESET;
            slew_ff <= PIN_RESET;
            drive_ff <= PIN_RESET;
            altEn_ff <= PIN_RESET;
            anaEn_ff <= PIN_RESET;
            outOnlyGpio_ff <= 1'b0;
            irqStat_ff <= IRQ_RESET;
            irqEn_ff <= IRQ_RESET;
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
            padOut_ff <= PIN_RESET;
            padOe_ff <= PIN_RESET;
            padPull_ff <= PIN_RESET;
            padSlew_ff <= PIN_RESET;
            padDrive_ff <= PIN_RESET;
            padInBuf_ff <= PIN_RESET;
        end else begin
            data_ff <= nxt_data;
            dir_ff <= nxt_dir;
            pull_ff <= nxt_pull;
            slew_ff <= nxt_slew;
            drive_ff <= nxt_drive;
            altEn_ff <= nxt_altEn;
            anaEn_ff <= nxt_anaEn;
            outOnlyGpio_ff <= nxt_outOnlyGpio;
            irqStat_ff <= nxt_irqStat;
            irqEn_ff <= nxt_irqEn;
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
            padOut_ff <= nxt_padOut;
            padOe_ff <= nxt_padOe;
            padPull_ff <= nxt_padPull;
            padSlew_ff <= nxt_padSlew;
            padDrive_ff <= nxt_padDrive;
            padInBuf_ff <= nxt_padInBuf;
        end
    end

    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;
    assign pinOut = padOut_ff;
    assign pinOe = padOe_ff;
    assign pinPullup = padPull_ff;
    assign pinSlew = padSlew_ff;
    assign pinDrive = padDrive_ff;
    assign pinInBufEn = padInBuf_ff;
endmodule : gps_port
`default_nettype wire

// file: verification/gps_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module gps_pin_model (
    input wire logic clk,
    input wire logic [gps_pkg::NUM_PINS-1:0] pinOut,
    input wire logic [gps_pkg::NUM_PINS-1:0] pinOe,
    input wire logic [gps_pkg::NUM_PINS-1:0] pinPullup,
    output logic [gps_pkg::NUM_PINS-1:0] pinIn
);
    import gps_pkg::*;
    // ----------
    // pad level
    // ----------
    // a floating pad toggles each cycle so a stale read never matches by luck
    logic flip = 1'b0;
    always @(posedge clk) flip <= ~flip;
    assign pinIn = (pinOe & pinOut) | (~pinOe & (pinPullup | {NUM_PINS{flip}}));
endmodule : gps_pin_model
`default_nettype wire

// file: verification/gps_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module gps_port_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    input wire logic [gps_pkg::NUM_PINS-1:0] pinOe,
    input wire logic [gps_pkg::NUM_PINS-1:0] pinOut,
    input wire logic [gps_pkg::NUM_PINS-1:0] pinPullup,
    input wire logic [gps_pkg::NUM_PINS-1:0] pinInBufEn,
    input wire logic stopReq,
    input wire logic wakeReq,
    input wire logic fullOffReq,
    input wire gps_pkg::gps_sleep_t sleepState,
    input wire logic irq
);
    import gps_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ----------
    // properties
    // ----------
    reset_quiet_a: assert property (disable iff (1'b0) !rst_b |-> !pinOe && !irq)
        else $error("pin drive or irq in reset");
    out_only_a: assert property (!pinInBufEn[OUT_ONLY_IDX] && !pinPullup[OUT_ONLY_IDX])
        else $error("output-only pin input side on");
    in_only_a: assert property (!pinOe[IN_ONLY_IDX])
        else $error("input-only pin driven");
    analog_off_a: assert property (((~pinInBufEn) & pinOe & 6'h2F) == 6'h00)
        else $error("driven pin with input buffer off");
    full_off_a: assert property (sleepState == SLP_FULL_OFF && $past(sleepState) == SLP_FULL_OFF
        |-> !pinOe && !pinPullup)
        else $error("pins active in full-off sleep");
    retain_hold_a: assert property (sleepState == SLP_RETAINED_PIN && $past(sleepState) ==
        SLP_RETAINED_PIN |-> $stable(pinOe) && $stable(pinOut) && $stable(pinPullup))
        else $error("pins moved while retained");
    full_stop_a: assert property (stopReq && fullOffReq && sleepState == SLP_RUN
        |=> sleepState == SLP_FULL_OFF)
        else $error("full-off sleep not entered");
    stop_state_a: assert property (stopReq && !fullOffReq && sleepState == SLP_RUN
        |=> sleepState inside {SLP_POWERED_LOGIC, SLP_RETAINED_PIN})
        else $error("wrong sleep state after stop");
    wake_a: assert property (wakeReq && sleepState != SLP_RUN |=> sleepState == SLP_RUN)
        else $error("no return to run on wake");
    stay_a: assert property (sleepState != SLP_RUN && !wakeReq |=> $stable(sleepState))
        else $error("sleep state left without wake");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error response outside access");
endmodule : gps_port_chk
bind gps_port gps_port_chk i_chk (.clk, .rst_b, .psel, .penable, .pslverr, .pinOe, .pinOut,
    .pinPullup, .pinInBufEn, .stopReq, .wakeReq, .fullOffReq, .sleepState, .irq);
`default_nettype wire

// file: verification/gps_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gps_port_tb;
    import gps_pkg::*;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, errS;
    logic dbgOe, dbgOut, stopReq, wakeReq, fullOffReq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdS, r;
    logic [5:0] pinIn, pinOut, pinOe, pinPullup, pinSlew, pinDrive, pinInBufEn;
    logic [5:0] periphDigReq, periphAnaReq, periphOe, periphOut;
    gps_sleep_t sleepState;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    gps_port i_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .pinIn, .pinOut, .pinOe, .pinPullup, .pinSlew, .pinDrive, .pinInBufEn,
        .periphDigReq, .periphAnaReq, .periphOe, .periphOut, .dbgOe, .dbgOut, .stopReq,
        .wakeReq, .fullOffReq, .sleepState, .irq);
    gps_pin_model i_pins (.clk, .pinOut, .pinOe, .pinPullup, .pinIn);
    // ----------
    // tasks
    // ----------
    task automatic complete_run();
        if (error_cnt == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
        r = rdS;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r, e);
    endtask : rd
    task automatic step();
        @(posedge clk);
        @(negedge clk);
    endtask : step
    task automatic slp(input logic s, input logic f);
        @(posedge clk);
        stopReq <= s;
        wakeReq <= !s;
        fullOffReq <= f;
        @(posedge clk);
        stopReq <= 1'b0;
        wakeReq <= 1'b0;
        @(negedge clk);
    endtask : slp
    // ----------
    // sequence
    // ----------
    // read data is taken at the accepting edge, before that edge's updates land
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (psel && penable && pready === 1'b1) begin
            rdS <= prdata;
            errS <= pslverr;
        end
        if (cyc == 4000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {rst_b, psel, penable, pwrite, dbgOe, dbgOut, stopReq, wakeReq, fullOffReq} = 9'h018;
        {paddr, pwdata} = '0;
        {periphDigReq, periphAnaReq, periphOe, periphOut} = 24'h0C10C0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        step();
        chk(32'(pinInBufEn), 32'h2F);
        chk(32'(pinOe), 32'h10);
        rd(OFS_PMSC, 32'h00);
        rd(OFS_DIR, 32'h00);
        wr(OFS_PULL, 32'h20);
        wr(OFS_DATA, 32'h0F);
        wr(OFS_DIR, 32'h0F);
        step();
        chk(32'(pinOe), 32'h1F);
        rd(OFS_DATA, 32'h2F);
        wr(OFS_PULL, 32'h3F);
        wr(OFS_SLEW, 32'h15);
        wr(OFS_DRIVE, 32'h2A);
        step();
        chk(32'({pinPullup, pinSlew, pinDrive}), 32'h0002056A);
        wr(OFS_ALT_EN, 32'h03);
        wr(OFS_ANA_EN, 32'h01);
        step();
        chk(32'(pinOe), 32'h1E);
        chk(32'(pinOut & 6'h0E), 32'h0C);
        chk(32'(pinInBufEn), 32'h2E);
        rd(OFS_DATA, 32'h2F);
        wr(OFS_DIR, 32'h0E);
        rd(OFS_DATA, 32'h2E);
        slp(1'b1, 1'b0);
        chk(32'(sleepState), 32'h1);
        chk(32'(irq), 32'h0);
        wr(OFS_IRQ_EN, 32'h03);
        chk(32'(irq), 32'h1);
        slp(1'b0, 1'b0);
        chk(32'(pinOe), 32'h1E);
        rd(OFS_IRQ_STAT, 32'h03);
        wr(OFS_IRQ_CLR, 32'h03);
        chk(32'(irq), 32'h0);
        rd(OFS_IRQ_CLR, 32'h00);
        wr(OFS_PMSC, 32'h03);
        rd(OFS_PMSC, 32'h01);
        wr(OFS_PMSC, 32'h00);
        rd(OFS_PMSC, 32'h01);
        slp(1'b1, 1'b0);
        chk(32'(sleepState), 32'h2);
        wr(OFS_DATA, 32'h00);
        step();
        chk(32'(pinOut & 6'h0E), 32'h0C);
        slp(1'b0, 1'b0);
        rd(OFS_PMSC, 32'h09);
        rd(OFS_DIR, 32'h00);
        chk(32'(pinOe), 32'h1E);
        wr(OFS_PMSC, 32'h05);
        rd(OFS_PMSC, 32'h01);
        chk(32'(pinOe), 32'h10);
        wr(OFS_PIN_CFG, 32'h01);
        step();
        chk(32'({pinOe, pinOut}), 32'h400);
        wr(OFS_DIR, 32'h0F);
        slp(1'b1, 1'b1);
        step();
        chk(32'(sleepState), 32'h3);
        chk(32'(pinOe | pinPullup), 32'h00);
        slp(1'b0, 1'b0);
        rd(OFS_DIR, 32'h00);
        rd(OFS_PMSC, 32'h01);
        rd(8'h3C, 32'h00);
        chk(32'(errS), 32'h1);
        complete_run();
    end
endmodule : gps_port_tb
`default_nettype wire
